// ---- src/pci_pkg.sv ----
`default_nettype none
package pci_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL     = 8'h11;
	localparam logic [7:0] IDX_EVT      = 8'h12;
	localparam logic [7:0] IDX_SYS_STAT = 8'h20;
	localparam logic [7:0] IDX_SYS_MASK = 8'h21;
	localparam logic [7:0] IDX_FIFO     = 8'h22;

	// phy_specific_control field positions
	localparam int unsigned CTRL_SCR_BYP  = 11;
	localparam int unsigned CTRL_DEPTH_LO = 8;
	localparam int unsigned CTRL_FD_COL   = 4;
	localparam int unsigned CTRL_POL      = 3;
	localparam int unsigned CTRL_TEST     = 2;
	localparam int unsigned CTRL_EVT_EN   = 1;
	localparam int unsigned CTRL_OE       = 0;
	localparam logic [1:0]  DEPTH_RST     = 2'h1;
	localparam logic        POL_RST       = 1'b1;

	// loopback fifo depths in nibbles per code
	localparam logic [3:0] DEPTH_C0  = 4'h4;
	localparam logic [3:0] DEPTH_C1  = 4'h5;
	localparam logic [3:0] DEPTH_C2  = 4'h6;
	localparam logic [3:0] DEPTH_C3  = 4'h8;
	localparam int unsigned FIFO_SLOTS = 8;
	localparam int unsigned PTR_W      = 3;
	localparam int unsigned FIFO_LVL_LSB = 0;
	localparam int unsigned FIFO_LIM_LSB = 4;

	// irq_status_enable_register: status in 13:8, enables in 5:0
	localparam int unsigned EVT_N      = 6;
	localparam int unsigned EVT_ST_LSB = 8;
	localparam int unsigned EVT_EN_LSB = 0;

	// system interrupt status / mask layout
	localparam int unsigned SYS_N   = 3;
	localparam int unsigned SYS_OVF = 0;
	localparam int unsigned SYS_UNF = 1;
	localparam int unsigned SYS_PDN = 2;

	typedef enum logic [3:0] {
		BUS_IDLE  = 4'b0001,
		BUS_WDATA = 4'b0010,
		BUS_RWAIT = 4'b0100,
		BUS_RDATA = 4'b1000
	} pci_bus_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] data;
	} pci_nib_t;

	typedef struct packed {
		logic       scr_bypass;
		logic [1:0] fifo_depth;
		logic       full_duplex_collision_enable;
		logic       irq_polarity;
		logic       test_irq;
		logic       evt_irq_en;
		logic       irq_out_en;
	} pci_ctrl_t;

	typedef struct packed {
		pci_bus_t                   bus;
		logic [7:0]                 addr;
		logic                       mapped;
		logic [31:0]                hrdata;
		pci_ctrl_t                  ctrl;
		logic [EVT_N-1:0]           evt_en;
		logic [SYS_N-1:0]           sys_mask;
		logic [FIFO_SLOTS-1:0][3:0] mem;
		logic [PTR_W-1:0]           wptr;
		logic [PTR_W-1:0]           rptr;
		logic [3:0]                 cnt;
		pci_nib_t                   tx;
		logic [3:0]                 tx_sym;
		logic                       col;
		logic                       pin_out;
		logic                       pdn;
		logic                       irq;
	} pci_state_t;
endpackage : pci_pkg
`default_nettype wire

// ---- src/pci_sticky.sv ----
`default_nettype none
// set-dominant sticky flags: an event in the clear cycle is kept
module pci_sticky #(
	parameter int unsigned N = 1
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         ce,
	input  wire logic [N-1:0] set,
	input  wire logic [N-1:0] clr,
	output logic      [N-1:0] flags
);
	logic [N-1:0] flags_r;
	logic [N-1:0] flags_nxt;

	always_comb begin
		flags_nxt = (flags_r & ~clr) | set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_r <= '0;
		end else if (ce) begin
			flags_r <= flags_nxt;
		end
	end

	assign flags = flags_r;
endmodule // pci_sticky
`default_nettype wire

// ---- src/pci_top.sv ----
`default_nettype none
module pci_top
	import pci_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [5:0]  evt_pulse,
	input  wire logic        col_in,
	input  wire logic        full_duplex,
	output logic             col_out,
	input  wire logic [3:0]  tx_plain,
	input  wire logic [3:0]  tx_scrambled,
	output logic      [3:0]  tx_sym,
	output logic             scr_bypass,
	input  wire pci_nib_t    lpbk_rx,
	input  wire logic        lpbk_take,
	output pci_nib_t         lpbk_tx,
	input  wire logic        pin_in,
	output logic             pin_out,
	output logic             pin_oe,
	output logic             powerdown,
	output logic             irq
);
	pci_state_t       s;
	pci_state_t       n;
	logic             acc;
	logic [15:0]      rd_val;
	logic [3:0]       limit;
	logic             wr_ok;
	logic             rd_ok;
	logic             evt_req;
	logic             req;
	logic [EVT_N-1:0] evt_flags;
	logic [EVT_N-1:0] evt_clr;
	logic [SYS_N-1:0] sys_flags;
	logic [SYS_N-1:0] sys_set;
	logic [SYS_N-1:0] sys_clr;

	pci_sticky #(.N(EVT_N)) u_evt (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.set     (evt_pulse),
		.clr     (evt_clr),
		.flags   (evt_flags)
	);

	pci_sticky #(.N(SYS_N)) u_sys (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.set     (sys_set),
		.clr     (sys_clr),
		.flags   (sys_flags)
	);

	always_comb begin
		n       = s;
		// hsize is not decoded: every access is taken as a whole word
		acc     = hsel & htrans[1] & hready;
		evt_clr = '0;
		sys_clr = '0;
		sys_set = '0;
		unique case (s.ctrl.fifo_depth)
			2'h0: limit = DEPTH_C0;
			2'h1: limit = DEPTH_C1;
			2'h2: limit = DEPTH_C2;
			2'h3: limit = DEPTH_C3;
		endcase

		// reserved bits stay zero in the read image
		rd_val = '0;
		if (s.mapped) begin
			unique case (s.addr)
				IDX_CTRL: begin
					rd_val[CTRL_SCR_BYP]         = s.ctrl.scr_bypass;
					rd_val[CTRL_DEPTH_LO +: 2]   = s.ctrl.fifo_depth;
					rd_val[CTRL_FD_COL]          = s.ctrl.full_duplex_collision_enable;
					rd_val[CTRL_POL]             = s.ctrl.irq_polarity;
					rd_val[CTRL_TEST]            = s.ctrl.test_irq;
					rd_val[CTRL_EVT_EN]          = s.ctrl.evt_irq_en;
					rd_val[CTRL_OE]              = s.ctrl.irq_out_en;
				end
				IDX_EVT: begin
					rd_val[EVT_ST_LSB +: EVT_N]  = evt_flags;
					rd_val[EVT_EN_LSB +: EVT_N]  = s.evt_en;
				end
				IDX_SYS_STAT: rd_val[SYS_N-1:0] = sys_flags;
				IDX_SYS_MASK: rd_val[SYS_N-1:0] = s.sys_mask;
				IDX_FIFO: begin
					rd_val[FIFO_LVL_LSB +: 4]    = s.cnt;
					rd_val[FIFO_LIM_LSB +: 4]    = limit;
				end
				default: rd_val = '0;
			endcase
		end

		// elastic loopback fifo, receive side writes, transmit side reads
		wr_ok = lpbk_rx.valid & (s.cnt < limit);
		rd_ok = lpbk_take & (s.cnt != 4'h0);
		sys_set[SYS_OVF] = lpbk_rx.valid & ~wr_ok;
		sys_set[SYS_UNF] = lpbk_take & ~rd_ok;
		if (wr_ok) begin
			n.mem[s.wptr] = lpbk_rx.data;
			n.wptr        = s.wptr + 3'h1;
		end
		if (rd_ok) begin
			n.tx.data = s.mem[s.rptr];
			n.rptr    = s.rptr + 3'h1;
		end
		n.tx.valid = rd_ok;
		n.cnt      = s.cnt + {3'h0, wr_ok} - {3'h0, rd_ok};

		unique case (s.bus)
			BUS_WDATA: begin
				if (s.mapped) begin
					unique case (s.addr)
						IDX_CTRL: begin
							n.ctrl.scr_bypass   = hwdata[CTRL_SCR_BYP];
							n.ctrl.fifo_depth   = hwdata[CTRL_DEPTH_LO +: 2];
							n.ctrl.full_duplex_collision_enable = hwdata[CTRL_FD_COL];
							n.ctrl.irq_polarity = hwdata[CTRL_POL];
							n.ctrl.test_irq     = hwdata[CTRL_TEST];
							n.ctrl.evt_irq_en   = hwdata[CTRL_EVT_EN];
							n.ctrl.irq_out_en   = hwdata[CTRL_OE];
							// a new depth restarts the fifo so it never holds more than the limit
							n.wptr = '0;
							n.rptr = '0;
							n.cnt  = '0;
						end
						IDX_EVT:      n.evt_en   = hwdata[EVT_EN_LSB +: EVT_N];
						IDX_SYS_STAT: sys_clr    = hwdata[SYS_N-1:0];
						IDX_SYS_MASK: n.sys_mask = hwdata[SYS_N-1:0];
						default: ;
					endcase
				end
			end
			BUS_RWAIT: begin
				n.hrdata = {16'h0000, rd_val};
				if (s.mapped && s.addr == IDX_EVT) begin
					evt_clr = '1;
				end
			end
			BUS_IDLE, BUS_RDATA: ;
			default: n.bus = BUS_IDLE;
		endcase

		if (s.bus == BUS_RWAIT) begin
			n.bus = BUS_RDATA;
		end else if (acc) begin
			n.bus    = hwrite ? BUS_WDATA : BUS_RWAIT;
			n.addr   = haddr[9:2];
			n.mapped = (haddr[31:10] == 22'h00_0000);
		end else begin
			n.bus = BUS_IDLE;
		end

		n.tx_sym = s.ctrl.scr_bypass ? tx_plain : tx_scrambled;
		// collision only in half duplex unless enabled
		n.col = col_in & (~full_duplex | s.ctrl.full_duplex_collision_enable);

		evt_req = s.ctrl.evt_irq_en & s.ctrl.irq_out_en & (|(evt_flags & s.evt_en));
		// forced test interrupt joins the gated events
		req = s.ctrl.test_irq | evt_req;
		n.pin_out = s.ctrl.irq_polarity ? ~req : req;
		// pin as active-low power-down input when not an output
		// old and new direction must both be input, else a driven level reads as power-down
		n.pdn = ~s.ctrl.irq_out_en & ~n.ctrl.irq_out_en & ~pin_in;
		sys_set[SYS_PDN] = n.pdn & ~s.pdn;
		n.irq = |(sys_flags & s.sys_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s                 <= '0;
			s.bus             <= BUS_IDLE;
			// depth code resets to five nibbles
			s.ctrl.fifo_depth   <= DEPTH_RST;
			s.ctrl.irq_polarity <= POL_RST;
			s.pin_out           <= POL_RST;
		end else if (ce) begin
			s <= n;
		end
	end

	assign hrdata     = s.hrdata;
	assign hreadyout  = (s.bus != BUS_RWAIT);
	assign hresp      = 1'b0;
	assign col_out    = s.col;
	assign tx_sym     = s.tx_sym;
	assign scr_bypass = s.ctrl.scr_bypass;
	assign lpbk_tx    = s.tx;
	assign pin_out    = s.pin_out;
	assign pin_oe     = s.ctrl.irq_out_en;
	assign powerdown  = s.pdn;
	assign irq        = s.irq;

	// checks
	logic first_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			first_r <= 1'b0;
		end else begin
			first_r <= 1'b1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_scr_path: assert property (hresetn && ce |=>
		tx_sym == ($past(scr_bypass) ? $past(tx_plain) : $past(tx_scrambled)))
		else $error("transmit symbol path wrong");
	a_rsv_read: assert property (s.bus == BUS_RDATA && s.addr == IDX_CTRL |->
		hrdata[10] == 1'b0 && hrdata[7:5] == 3'h0)
		else $error("reserved control bits not zero");
	a_fifo_bound: assert property (s.cnt <= limit)
		else $error("loopback fifo above depth");
	a_depth_reset: assert property (!first_r |-> s.ctrl.fifo_depth == DEPTH_RST)
		else $error("depth code reset wrong");
	a_fifo_ovf: assert property (ce && lpbk_rx.valid && s.cnt == limit |=>
		sys_flags[SYS_OVF]) else $error("overflow not flagged");
	a_col_gate: assert property (ce && full_duplex &&
		!s.ctrl.full_duplex_collision_enable |=> !col_out)
		else $error("collision leaked in full duplex");
	a_col_fd: assert property (ce && full_duplex && col_in &&
		s.ctrl.full_duplex_collision_enable |=> col_out)
		else $error("full duplex collision missing");
	a_pin_pol: assert property (ce && s.ctrl.test_irq |=>
		pin_out == !$past(s.ctrl.irq_polarity)) else $error("interrupt level wrong");
	a_test_hold: assert property ((ce && s.ctrl.test_irq && !s.ctrl.irq_polarity) [*3] |=>
		pin_out) else $error("test interrupt not held");
	a_evt_gate: assert property (ce && !s.ctrl.test_irq &&
		(!s.ctrl.evt_irq_en || !s.ctrl.irq_out_en) |=> pin_out == $past(s.ctrl.irq_polarity))
		else $error("event passed closed gate");
	a_pin_dir: assert property (pin_oe == s.ctrl.irq_out_en &&
		(!s.ctrl.irq_out_en || !powerdown)) else $error("pin direction wrong");
	a_evt_sticky: assert property (ce && |evt_pulse |=>
		(evt_flags & $past(evt_pulse)) == $past(evt_pulse)) else $error("event lost");
	a_read_wait: assert property (ce && s.bus == BUS_RWAIT |-> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");

	a_evt_clear: assert property (ce && s.bus == BUS_RWAIT && s.addr == IDX_EVT &&
		s.mapped && evt_pulse == '0 |=> evt_flags == '0) else $error("event status not cleared");
	a_evt_pass: assert property (ce && s.ctrl.evt_irq_en && s.ctrl.irq_out_en &&
		|(evt_flags & s.evt_en) |=> pin_out == !$past(s.ctrl.irq_polarity))
		else $error("enabled event did not reach pin");
	a_col_half: assert property (ce && !full_duplex && col_in |=> col_out)
		else $error("half duplex collision missing");
	a_pdn_set: assert property (ce && s.bus != BUS_WDATA && !s.ctrl.irq_out_en &&
		!pin_in |=> powerdown) else $error("power-down request missed");
	a_fifo_unf: assert property (ce && lpbk_take && s.cnt == 4'h0 |=>
		sys_flags[SYS_UNF] && !lpbk_tx.valid) else $error("underflow not flagged");
	// a depth change restarts the fifo, so the new limit can never be exceeded
	a_fifo_flush: assert property (ce && s.bus == BUS_WDATA && s.mapped &&
		s.addr == IDX_CTRL |=> s.cnt == 4'h0) else $error("fifo not emptied on control write");
	a_irq_level: assert property (ce |=> irq == |($past(sys_flags) & $past(s.sys_mask)))
		else $error("system interrupt level wrong");
	a_resp_okay: assert property (!hresp)
		else $error("error response driven");
	// a frozen cycle must leave every field alone, fifo pointers and bus state included
	a_ce_hold: assert property (!ce |=> s == $past(s))
		else $error("state moved while frozen");

	// main scenarios
	c_evt_read: cover property (s.bus == BUS_RWAIT && s.addr == IDX_EVT && |evt_flags);
	c_fifo_full: cover property (s.cnt == DEPTH_C3);
	c_evt_irq: cover property (pin_oe && !pin_out && !s.ctrl.test_irq);
	c_pdn: cover property ($rose(powerdown));
	c_fd_col: cover property (full_duplex && col_out);
endmodule // pci_top
`default_nettype wire

// ---- verif/pci_host.sv ----
`default_nettype none
// host side of the shared interrupt / power-down pin
module pci_host (
	input  wire logic pin_out,
	input  wire logic pin_oe,
	input  wire logic pdn_req,
	output logic      pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin direction
	// a pull-up holds the wire high; the host pulls low only while the block listens
	assign pin_in = pin_oe ? pin_out : !pdn_req;
endmodule // pci_host
`default_nettype wire

// ---- verif/phy_control_interrupt_output_bench.sv ----
`default_nettype none
module phy_control_interrupt_output_bench
	import pci_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A_CTRL = {22'h0, IDX_CTRL, 2'b00};
	localparam logic [31:0] A_EVT  = {22'h0, IDX_EVT, 2'b00};
	localparam logic [31:0] A_STAT = {22'h0, IDX_SYS_STAT, 2'b00};
	localparam logic [31:0] A_MASK = {22'h0, IDX_SYS_MASK, 2'b00};
	localparam logic [31:0] A_FIFO = {22'h0, IDX_FIFO, 2'b00};
	logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, col_in, full_duplex;
	logic        col_out, scr_bypass, lpbk_take, pin_in, pin_out, pin_oe, powerdown, irq;
	logic        pdn_req;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [5:0]  evt_pulse;
	logic [3:0]  tx_plain, tx_scrambled, tx_sym;
	pci_nib_t    lpbk_rx, lpbk_tx;
	int          fails = 0;
	int          cmp_count = 0;
	logic [3:0]  lim [4] = '{4'h4, 4'h5, 4'h6, 4'h8};

	pci_top u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .evt_pulse, .col_in, .full_duplex,
		.col_out, .tx_plain, .tx_scrambled, .tx_sym, .scr_bypass, .lpbk_rx, .lpbk_take,
		.lpbk_tx, .pin_in, .pin_out, .pin_oe, .powerdown, .irq);
	pci_host u_host (.pin_out, .pin_oe, .pdn_req, .pin_in);

	function automatic logic [31:0] ctl(logic b, logic [1:0] d, logic f, p, t, e, o);
		return (32'(b) << CTRL_SCR_BYP) | (32'(d) << CTRL_DEPTH_LO) | (32'(f) << CTRL_FD_COL)
			| (32'(p) << CTRL_POL) | (32'(t) << CTRL_TEST) | (32'(e) << CTRL_EVT_EN) | 32'(o);
	endfunction

	task automatic tally_and_finish();
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single word transfer; the master waits for hready in both phases
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask

	task automatic rdc(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	task automatic pulse();
		@(posedge hclk);
		evt_pulse <= 6'h01;
		@(posedge hclk);
		evt_pulse <= 6'h00;
	endtask

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	initial begin
		repeat (5000) @(posedge hclk);
		fails++;
		tally_and_finish();
	end

	initial begin
		{hsel, hwrite, col_in, full_duplex, lpbk_take, pdn_req} = '0;
		haddr = '0;
		hwdata = '0;
		htrans = '0;
		evt_pulse = '0;
		lpbk_rx = '0;
		ce = 1'b1;
		hsize = 3'h2;
		tx_plain = 4'h3;
		tx_scrambled = 4'hc;
		hresetn = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(A_CTRL, 32'h0000_0108);
		chk(32'(pin_out), 32'h1);
		chk(32'(tx_sym), 32'hc);
		wr(A_CTRL, 32'hffff_ffff);
		rdc(A_CTRL, 32'h0000_0b1f);
		chk(32'(scr_bypass), 32'h1);
		chk(32'(tx_sym), 32'h3);
		col_in <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(A_CTRL, ctl(0, 2'h1, i[1], 1, 0, 0, 0));
			full_duplex <= i[0];
			tick(2);
			chk(32'(col_out), 32'(!i[0] || i[1]));
		end
		// fill past the limit of every depth code; the control write flushes first
		// software steps through every depth code
		for (int d = 0; d < 4; d++) begin
			wr(A_CTRL, ctl(0, 2'(d), 0, 1, 0, 0, 0));
			for (int k = 0; k < 9; k++) begin
				@(posedge hclk);
				lpbk_rx <= '{1'b1, 4'(k)};
			end
			@(posedge hclk);
			lpbk_rx <= '0;
			rdc(A_FIFO, {24'h0, lim[d], lim[d]});
		end
		@(posedge hclk);
		lpbk_take <= 1'b1;
		@(posedge hclk);
		lpbk_take <= 1'b0;
		#1 chk(32'(lpbk_tx), 32'h0000_0010);
		rdc(A_FIFO, 32'h0000_0087);
		rdc(A_STAT, 32'h0000_0001);
		chk(32'(irq), 32'h0);
		wr(A_MASK, 32'h0000_0001);
		tick(2);
		chk(32'(irq), 32'h1);
		wr(A_STAT, 32'h0000_0001);
		tick(2);
		chk(32'(irq), 32'h0);
		pdn_req <= 1'b1;
		tick(3);
		chk(32'(powerdown), 32'h1);
		rdc(A_STAT, 32'h0000_0004);
		pdn_req <= 1'b0;
		wr(A_EVT, 32'h0000_0001);
		wr(A_CTRL, ctl(0, 2'h1, 0, 1, 0, 1, 1));
		pulse();
		tick(2);
		chk(32'(pin_out), 32'h0);
		rdc(A_EVT, 32'h0000_0101);
		tick(2);
		chk(32'(pin_out), 32'h1);
		wr(A_CTRL, ctl(0, 2'h1, 0, 1, 0, 0, 1));
		pulse();
		tick(2);
		chk(32'(pin_out), 32'h1);
		rdc(A_EVT, 32'h0000_0101);
		// forced request under both polarities, then released
		for (int t = 0; t < 3; t++) begin
			wr(A_CTRL, ctl(0, 2'h1, 0, t == 0, t < 2, 0, 1));
			tick(2);
			chk(32'(pin_out), 32'(t == 1));
		end
		chk(32'(pin_oe), 32'h1);
		// an event while the clock enable is low must be lost
		@(posedge hclk);
		ce <= 1'b0;
		pulse();
		@(posedge hclk);
		ce <= 1'b1;
		rdc(A_EVT, 32'h0000_0001);
		// a take from the empty fifo flags underflow and hands nothing over
		@(posedge hclk);
		lpbk_take <= 1'b1;
		@(posedge hclk);
		lpbk_take <= 1'b0;
		#1 chk(32'(lpbk_tx.valid), 32'h0);
		rdc(A_STAT, 32'h0000_0006);
		wr(32'h0000_004c, 32'hffff_ffff);
		rdc(32'h0000_004c, 32'h0);
		chk(32'(hresp), 32'h0);
		tally_and_finish();
	end
endmodule // phy_control_interrupt_output_bench
`default_nettype wire
